// ==== led_pwm_defines.svh ====
// Register map, field positions, reset values and bus constants
`ifndef LED_PWM_DEFINES_SVH
`define LED_PWM_DEFINES_SVH
`define SLAVE_ADDR_FIXED 5'h0f
`define REG_SOFT_OFF 8'h00
`define REG_DUTY_FIRST 8'h01
`define REG_DUTY_LAST 8'h24
`define REG_COMMIT 8'h25
`define REG_CTRL_FIRST 8'h26
`define REG_CTRL_LAST 8'h49
`define REG_GATE 8'h4a
`define REG_RESTORE 8'h4f
`define COMMIT_KEY 8'h00
`define DUTY_RESET 8'h00
`define CTRL_RESET 3'h0
`define SOFT_OFF_RESET 1'h0
`define GATE_RESET 1'h0
`define SOFT_OFF_POS 0
`define GATE_POS 0
`define CTRL_ON_POS 0
`define CTRL_SCALE_LSB 1
`define CTRL_SCALE_MSB 2
`define BIT_ACK_SLOT 4'h8
`define BIT_LAST_DATA 4'h7
`define MAX_CHANNELS 36
`endif

// ==== led_pwm_pkg.sv ====
// Types shared by the LED duty register slave
package led_pwm_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_ADDR = 2'b01,
    LINK_PTR = 2'b10,
    LINK_DATA = 2'b11
  } link_state_e;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } wr_word_s;
  typedef struct packed {
    logic [1:0] scale;
    logic on;
  } chan_ctrl_s;
endpackage

// ==== i2c_led_pwm_register_slave.sv ====
// Write-only two-wire slave with shadowed duty registers and LED PWM
//
// Overview of operation
// - Answer address 01111 plus two strap bits, then a zero write bit.
// - Strap to ground 00, supply 11, clock line 01, data line 10.
// - Data bits sampled on rising clock; idle data line stays high.
// - Data falling with clock high starts a frame and address compare.
// - Matched address is acknowledged by pulling data low in slot nine.
// - Pointer byte follows the address; it is acknowledged and loaded.
// - Each data byte, MSB first, is acknowledged in the ninth slot.
// - Data rising with clock high ends the write transfer.
// - Pointer increments after every data byte for consecutive writes.
// - Pointers 01h to 24h are duty of channels 1 to 36, reset zero.
// - Pointers 26h to 49h are per-channel enable and current scale.
// - Register 00h bit 0 is soft_off_bit, other bits unused, reset 0.
// - Eight-bit duty gives 256 brightness steps per channel.
// - On-time fraction per PWM period equals duty divided by 256.
// - Duty and control go to shadows; writing 00h to 25h commits all.
// - Control holds channel_on at bit 0, current_scale at bits 2:1.
// - Pointer 4Ah is a global gate for all channel outputs.
// - Any write to pointer 4Fh returns every register to default.
// - soft_off_bit zero turns all outputs off, registers keep values.
// - current_scale 00 full, 01 half, 10 third, 11 quarter current.
// - Gate bit 0 normal when 0, forces all outputs off when 1.
// - Low shutdown_pin_n forces all outputs off.
`timescale 1ns/1ps
`include "led_pwm_defines.svh"

module i2c_led_pwm_register_slave #(
  parameter int CHANNELS = `MAX_CHANNELS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap,
  input wire logic shutdown_pin_n,
  output logic [CHANNELS-1:0] led_channel_outputs,
  output logic [2*CHANNELS-1:0] led_current_scale
);
  import led_pwm_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  // The pointer map has room for no more than the documented channels
  generate
    if (CHANNELS < 1 || CHANNELS > `MAX_CHANNELS) begin : g_bad
      $error("CHANNELS must lie between 1 and 36");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers in the system clock domain
  // ****************************************************************
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic strap_s1_reg, strap_s2_reg;
  logic shdn_s1_reg, shdn_s2_reg;

  always_ff @(posedge clk) begin
    scl_s1_reg <= scl_clk;
    scl_s2_reg <= scl_s1_reg;
    scl_s3_reg <= scl_s2_reg;
    sda_s1_reg <= sda_in;
    sda_s2_reg <= sda_s1_reg;
    sda_s3_reg <= sda_s2_reg;
    strap_s1_reg <= addr_strap;
    strap_s2_reg <= strap_s1_reg;
    shdn_s1_reg <= shutdown_pin_n;
    shdn_s2_reg <= shdn_s1_reg;
  end

  // ****************************************************************
  // Address strap decode
  // ****************************************************************
  // The strap may be tied to a bus line, so it is classified by
  // watching which line it follows; a tie to a bus line reads as a
  // supply tie until the tied line has gone low at least once.
  logic strap_lo_seen_reg, strap_hi_seen_reg;
  logic strap_not_scl_reg, strap_not_sda_reg;
  logic [1:0] strap_code_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      strap_lo_seen_reg <= 1'b0;
      strap_hi_seen_reg <= 1'b0;
      strap_not_scl_reg <= 1'b0;
      strap_not_sda_reg <= 1'b0;
    end else begin
      if (!strap_s2_reg) strap_lo_seen_reg <= 1'b1;
      if (strap_s2_reg) strap_hi_seen_reg <= 1'b1;
      if (strap_s2_reg != scl_s2_reg) strap_not_scl_reg <= 1'b1;
      if (strap_s2_reg != sda_s2_reg) strap_not_sda_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      strap_code_reg <= 2'h3;
    end else if (!strap_hi_seen_reg) begin
      strap_code_reg <= 2'h0;
    end else if (!strap_lo_seen_reg) begin
      strap_code_reg <= 2'h3;
    end else if (!strap_not_scl_reg) begin
      strap_code_reg <= 2'h1;
    end else if (!strap_not_sda_reg) begin
      strap_code_reg <= 2'h2;
    end else begin
      strap_code_reg <= 2'h3;
    end
  end

  // ****************************************************************
  // Start detection on the data line
  // ****************************************************************
  // The bus clock stops between frames, so the start must be caught
  // by the data edge itself; the link side clears it once consumed.
  logic start_flag;
  logic cond_clr_reg;
  logic link_rst_reg;
  logic start_clr;

  // The bus clock is still during reset, so the link side is reset
  // from a registered copy of srst; it releases one clock after srst, whatever the bus is doing
  always_ff @(posedge clk) begin
    link_rst_reg <= srst;
  end

  assign start_clr = cond_clr_reg | link_rst_reg;

  // start is data falling with clock high
  always_ff @(negedge sda_in or posedge start_clr) begin
    if (start_clr) begin
      start_flag <= 1'b0;
    end else if (scl_clk) begin
      start_flag <= 1'b1;
    end
  end

  // ****************************************************************
  // Link clock domain
  // ****************************************************************
  logic [1:0] code_s1_reg, code_s2_reg;
  logic frame_tog_reg, frame_seen_reg;
  logic ack_want_reg;
  link_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic byte_ok_reg;
  logic [7:0] ptr_reg;
  wr_word_s wr_word_reg;
  logic wr_tog_reg;
  logic [7:0] byte_rx;

  assign byte_rx = {shift_reg[6:0], sda_in};

  // Strap code is static in use, so a plain level crossing serves
  always_ff @(posedge scl_clk) begin
    code_s1_reg <= strap_code_reg;
    code_s2_reg <= code_s1_reg;
  end

  // Falling edge: take the start and drive the acknowledge slot
  always_ff @(negedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      frame_tog_reg <= 1'b0;
      cond_clr_reg <= 1'b0;
      ack_want_reg <= 1'b0;
    end else begin
      frame_tog_reg <= frame_tog_reg ^ start_flag;
      cond_clr_reg <= start_flag;
      // hold data low through slot nine
      ack_want_reg <= (bit_cnt_reg == `BIT_ACK_SLOT) && byte_ok_reg;
    end
  end

  // Rising edge: sample data while the clock is high
  always_ff @(posedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      frame_seen_reg <= 1'b0;
      state_reg <= LINK_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_ok_reg <= 1'b0;
      ptr_reg <= 8'h00;
      wr_word_reg <= '0;
      wr_tog_reg <= 1'b0;
    end else begin
      frame_seen_reg <= frame_tog_reg;
      if (frame_tog_reg != frame_seen_reg) begin
        state_reg <= LINK_ADDR;
        bit_cnt_reg <= 4'h1;
        shift_reg <= {7'h00, sda_in};
        byte_ok_reg <= 1'b0;
      end else if (state_reg != LINK_IDLE) begin
        if (bit_cnt_reg == `BIT_ACK_SLOT) begin
          bit_cnt_reg <= 4'h0;
          byte_ok_reg <= 1'b0;
          if (!byte_ok_reg) state_reg <= LINK_IDLE;
        end else begin
          shift_reg <= byte_rx;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `BIT_LAST_DATA) begin
            case (state_reg)
              LINK_ADDR: begin
                // fixed bits, strap bits, write bit
                byte_ok_reg <= byte_rx ==
                  {`SLAVE_ADDR_FIXED, code_s2_reg, 1'b0};
                state_reg <= LINK_PTR;
              end
              LINK_PTR: begin
                ptr_reg <= byte_rx;
                byte_ok_reg <= 1'b1;
                state_reg <= LINK_DATA;
              end
              LINK_DATA: begin
                // data byte passed on and acknowledged
                wr_word_reg <= '{ptr: ptr_reg, data: byte_rx};
                wr_tog_reg <= ~wr_tog_reg;
                ptr_reg <= ptr_reg + 8'h01;
                byte_ok_reg <= 1'b1;
              end
              default: begin
                byte_ok_reg <= 1'b0;
              end
            endcase
          end
        end
      end
    end
  end

  // ****************************************************************
  // Crossing back to the system clock
  // ****************************************************************
  // The word register stays still for at least eight bus clocks after
  // its toggle moves, far longer than the three-flop toggle path.
  logic tog_s1_reg, tog_s2_reg, tog_s3_reg;
  logic ack_s1_reg, ack_s2_reg;
  logic bus_idle_reg;
  logic wr_evt;
  wr_word_s word;

  always_ff @(posedge clk) begin
    tog_s1_reg <= wr_tog_reg;
    tog_s2_reg <= tog_s1_reg;
    tog_s3_reg <= tog_s2_reg;
    ack_s1_reg <= ack_want_reg;
    ack_s2_reg <= ack_s1_reg;
  end

  assign wr_evt = tog_s2_reg ^ tog_s3_reg;
  assign word = wr_word_reg;

  // stop ends the transfer and frees the line
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_idle_reg <= 1'b1;
    end else if (scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg) begin
      bus_idle_reg <= 1'b1;
    end else if (scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg) begin
      bus_idle_reg <= 1'b0;
    end
  end

  // Open drain: the line is only ever pulled low
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= ack_s2_reg && !bus_idle_reg;
    end
  end

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic soft_off_bit_reg, gate_reg;
  logic commit, restore;
  logic run;

  assign commit = wr_evt && word.ptr == `REG_COMMIT
    && word.data == `COMMIT_KEY;
  assign restore = wr_evt && word.ptr == `REG_RESTORE;

  always_ff @(posedge clk) begin
    if (srst || restore) begin
      soft_off_bit_reg <= `SOFT_OFF_RESET;
      gate_reg <= `GATE_RESET;
    end else if (wr_evt) begin
      if (word.ptr == `REG_SOFT_OFF) begin
        soft_off_bit_reg <= word.data[`SOFT_OFF_POS];
      end
      if (word.ptr == `REG_GATE) begin
        gate_reg <= word.data[`GATE_POS];
      end
    end
  end

  assign run = soft_off_bit_reg && !gate_reg && shdn_s2_reg;

  logic [7:0] pwm_cnt_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_cnt_reg <= 8'h00;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // Per-channel shadows, active copies and outputs
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i++) begin : g_ch
      logic [7:0] duty_sh_reg, duty_act_reg;
      chan_ctrl_s ctrl_sh_reg, ctrl_act_reg;
      logic hit_duty, hit_ctrl;

      assign hit_duty = wr_evt && word.ptr == `REG_DUTY_FIRST + 8'(i);
      assign hit_ctrl = wr_evt && word.ptr == `REG_CTRL_FIRST + 8'(i);

      always_ff @(posedge clk) begin
        if (srst || restore) begin
          duty_sh_reg <= `DUTY_RESET;
          ctrl_sh_reg <= `CTRL_RESET;
        end else begin
          if (hit_duty) duty_sh_reg <= word.data;
          if (hit_ctrl) begin
            ctrl_sh_reg <= '{
              scale: word.data[`CTRL_SCALE_MSB:`CTRL_SCALE_LSB],
              on: word.data[`CTRL_ON_POS]};
          end
        end
      end

      always_ff @(posedge clk) begin
        if (srst || restore) begin
          duty_act_reg <= `DUTY_RESET;
          ctrl_act_reg <= `CTRL_RESET;
        end else if (commit) begin
          duty_act_reg <= duty_sh_reg;
          ctrl_act_reg <= ctrl_sh_reg;
        end
      end

      always_ff @(posedge clk) begin
        if (srst) begin
          led_channel_outputs[i] <= 1'b0;
          led_current_scale[2*i+1:2*i] <= 2'h0;
        end else begin
          // on for duty of 256 counts
          led_channel_outputs[i] <= run && ctrl_act_reg.on
            && pwm_cnt_reg < duty_act_reg;
          // scale code sent to the current sink
          led_current_scale[2*i+1:2*i] <= ctrl_act_reg.scale;
        end
      end
    end
  endgenerate

endmodule

// ==== i2c_led_pwm_register_slave_monitor.sv ====
// Port-level checker for the LED duty register slave
`timescale 1ns/1ps
module i2c_led_pwm_register_slave_monitor #(
  parameter int CHANNELS = 36
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_strap,
  input wire logic shutdown_pin_n,
  input wire logic [CHANNELS-1:0] led_channel_outputs,
  input wire logic [2*CHANNELS-1:0] led_current_scale
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // Acknowledge and output checks
  // ****************************************
  property p_drive_low;
    sda_oe |-> !sda_out;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("sda driven high");
  // Ack must start shortly after a falling bus clock, never mid high phase
  property p_ack_start;
    $rose(sda_oe) |-> !scl_clk &&
      ($past(scl_clk, 3) || $past(scl_clk, 4) || $past(scl_clk, 5));
  endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack late");
  property p_ack_hold;
    sda_oe && scl_clk |=> sda_oe || !scl_clk;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
  property p_ack_len;
    $rose(sda_oe) |-> sda_oe [*8];
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack too short");
  property p_ack_end;
    $fell(sda_oe) |-> !scl_clk &&
      ($past(scl_clk, 3) || $past(scl_clk, 4) || $past(scl_clk, 5));
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("ack end wrong");
  property p_hw_off;
    !shutdown_pin_n [*5] |-> led_channel_outputs == '0;
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("led on in shutdown");
  property p_reset_out;
    $fell(srst) |-> led_channel_outputs == '0 && led_current_scale == '0
      && !sda_oe;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset value");
  // Active scale moves only on a commit or restore byte, both landing with clock high
  property p_scale_commit;
    !$stable(led_current_scale) && !$past(srst) |-> scl_clk;
  endproperty
  a_scale_commit: assert property (p_scale_commit) else $error("scale");
endmodule

bind i2c_led_pwm_register_slave i2c_led_pwm_register_slave_monitor #(
  .CHANNELS(CHANNELS)
) monitor_inst (
  .clk(clk),
  .srst(srst),
  .scl_clk(scl_clk),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe),
  .addr_strap(addr_strap),
  .shutdown_pin_n(shutdown_pin_n),
  .led_channel_outputs(led_channel_outputs),
  .led_current_scale(led_current_scale)
);

// ==== i2c_master_model.sv ====
// Bus master model that writes frames to the LED duty slave
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ****************************************
  // Frame timing: low 1.3 us, high 1.2 us
  // ****************************************
  // idle data line left high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data changes only while clock low
  task automatic put_bit(input logic b, output logic seen);
    tick(60);
    sda_pull <= ~b;
    tick(70);
    scl <= 1'b1;
    tick(120);
    seen = sda;
    scl <= 1'b0;
  endtask
  task automatic frame(input logic [63:0] b, input int n,
                       output logic [7:0] nack);
    logic s;
    nack = 8'h00;
    tick(60);
    // start, data falls with clock high
    sda_pull <= 1'b1;
    tick(60);
    scl <= 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 63 - 8 * i; k > 55 - 8 * i; k--) put_bit(b[k], s);
      put_bit(1'b1, s);
      nack[i] = s;
      // give up on a missing ack
      if (s) break;
    end
    tick(60);
    sda_pull <= 1'b1;
    tick(70);
    scl <= 1'b1;
    tick(60);
    // stop, data rises with clock high
    sda_pull <= 1'b0;
    tick(130);
  endtask
endmodule

// ==== i2c_led_pwm_register_slave_tb.sv ====
// Self-checking bench for the LED duty register slave
`timescale 1ns/1ps
module i2c_led_pwm_register_slave_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] addr;
    logic nack;
  } strap_row_s;
  // Strap modes: 0 ground, 1 supply, 2 clock line, 3 data line
  strap_row_s rows [6] = '{'{2'h0, 8'h78, 1'h0}, '{2'h0, 8'h79, 1'h1},
    '{2'h0, 8'h7a, 1'h1}, '{2'h1, 8'h7e, 1'h0}, '{2'h2, 8'h7a, 1'h0},
    '{2'h3, 8'h7c, 1'h0}};
  localparam logic [35:0] on_cnt = {9'h000, 9'h0ff, 9'h040, 9'h080};
  logic clk, srst, scl, m_pull, sda, sda_oe, sda_out, shutdown_pin_n;
  logic addr_strap;
  logic [1:0] strap_mode;
  logic [7:0] nk;
  logic [35:0] led;
  logic [71:0] scale;
  int err_count, checked;
  // Open drain line with pull-up: low if anyone pulls
  assign sda = ~(m_pull | (sda_oe & ~sda_out));
  assign addr_strap = strap_mode == 2'h2 ? scl :
                      strap_mode == 2'h3 ? sda : strap_mode[0];
  i2c_led_pwm_register_slave i2c_led_pwm_register_slave_inst (
    .clk(clk), .srst(srst), .scl_clk(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .shutdown_pin_n(shutdown_pin_n), .led_channel_outputs(led),
    .led_current_scale(scale));
  i2c_master_model i2c_master_model_inst (
    .clk(clk), .sda(sda), .scl(scl), .sda_pull(m_pull));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [71:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset;
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic send(input logic [63:0] b, input int n);
    i2c_master_model_inst.frame(b, n, nk);
    check("byte acks", 72'(nk), 72'h0);
  endtask
  // Counts on-cycles of channels 1..4 over one 256-cycle period
  task automatic pwm_check(input string what, input logic [35:0] exp);
    logic [35:0] c;
    c = '0;
    repeat (256) begin
      @(posedge clk);
      for (int i = 0; i < 4; i++) c[9*i +: 9] += 9'(led[i]);
    end
    check(what, 72'(c), 72'(exp));
    check("idle channels", 72'(led[35:4]), 72'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Bus timing keeps runs long; this only catches a hang
  initial begin
    repeat (98000) @(posedge clk);
    err_count++;
    print_verdict;
  end
  initial begin
    srst = 1'b1;
    shutdown_pin_n = 1'b1;
    strap_mode = 2'h0;
    err_count = 0;
    checked = 0;
    do_reset;
    check("led reset", 72'(led), 72'h0);
    check("scale reset", scale, 72'h0);
    foreach (rows[r]) begin
      strap_mode <= rows[r].mode;
      // Strap is static in use, so every tie starts from a fresh reset
      do_reset;
      i2c_master_model_inst.frame({rows[r].addr, 56'h0}, 1, nk);
      check("addr ack", 72'(nk), 72'(rows[r].nack));
    end
    strap_mode <= 2'h0;
    do_reset;
    send(64'h7800_0180_40ff_ff00, 7);
    send(64'h7826_0103_0506_0000, 6);
    check("shadow held", scale, 72'h0);
    send(64'h7825_0100_0000_0000, 3);
    check("bad commit", scale, 72'h0);
    send(64'h7825_0000_0000_0000, 3);
    check("commit scale", scale, 72'he4);
    pwm_check("duty", on_cnt);
    shutdown_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    pwm_check("pin off", 36'h0);
    shutdown_pin_n <= 1'b1;
    repeat (8) @(posedge clk);
    send(64'h7800_0000_0000_0000, 3);
    pwm_check("soft off", 36'h0);
    send(64'h7800_0100_0000_0000, 3);
    pwm_check("soft on", on_cnt);
    send(64'h784a_0100_0000_0000, 3);
    pwm_check("gate off", 36'h0);
    send(64'h784f_5a00_0000_0000, 3);
    check("restore", scale, 72'h0);
    print_verdict;
  end
endmodule
